// ==== design/tw_link_defs.svh ====
// register indices, field positions, reset values and timing counts
// assumes: included by the link master, its package, the driver model and the bench
`ifndef TW_LINK_DEFS_SVH
`define TW_LINK_DEFS_SVH

// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define TW_IDX_EQ      8'hf1
`define TW_IDX_LOSS    8'hf2
`define TW_IDX_RX3     8'hf4
`define TW_IDX_TX2     8'hf5
`define TW_IDX_TX3     8'hf6
`define TW_IDX_SETUP   8'hf7
`define TW_IDX_CTRL    8'hf8
`define TW_IDX_ADDR    8'hf9
`define TW_IDX_WDATA   8'hfa
`define TW_IDX_RDATA   8'hfb
`define TW_IDX_STAT1   8'hfc
`define TW_IDX_STAT2   8'hfd
`define TW_IDX_ACCESS  8'he0

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define TW_SEL_MSB      1
`define TW_IGNORE_BIT   2
`define TW_DIS_BIT      0
`define TW_START_BIT    1
`define TW_POR_BIT      7
`define TW_READ_BIT     7
`define TW_ACC_PW1      0
`define TW_ACC_PW2      1
`define TW_ACC_RW       2
`define TW_ACC_RD       3
`define TW_REG_RESET    8'h00
`define TW_SEL_DEVICE   2'h1
`define TW_SEL_ALL      2'h3

// ---------------------------------------------------------------
// addresses inside the laser driver
// ---------------------------------------------------------------
`define TW_DRV_EQ      8'h01
`define TW_DRV_LOSS    8'h02
`define TW_DRV_RX3     8'h03
`define TW_DRV_TX2     8'h04
`define TW_DRV_TX3     8'h05
`define TW_DRV_STAT1   8'h0e
`define TW_DRV_STAT2   8'h0f

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TW_CLK_NS         5
`define TW_SCLK_PERIOD_NS 160
`define TW_SCLK_HALF_CYC  ((`TW_SCLK_PERIOD_NS / 2 + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_REFRESH_US     1000
`define TW_REFRESH_CYC    (`TW_REFRESH_US * 1000 / `TW_CLK_NS)
`define TW_FRAME_BITS     16
`define TW_PUSH_LAST      3'h4

`endif

// ==== design/tw_link_pkg.sv ====
// types of the three-wire link master
// assumes: tw_link_defs.svh on the include path
`include "tw_link_defs.svh"
package tw_link_pkg;
	typedef enum logic {ST_IDLE, ST_SHIFT} link_state_t;
	typedef enum logic [1:0] {K_MANUAL, K_PUSH, K_STAT1, K_STAT2} xfer_kind_t;
	typedef struct packed {
		logic [7:0]  eq, loss, rx3, tx2, tx3;
		logic [2:0]  setup;
		logic        dis, start;
		logic [7:0]  addr, wdata, rdata, stat1, stat2;
		logic [3:0]  acc;
		logic [31:0] prdata;
		logic        pslverr;
		logic        txd_m, txd_s, txd_p, poa_m, poa_s, poa_p, sdi_m, sdi_s;
		link_state_t state;
		xfer_kind_t  kind;
		logic        is_read, push_active, push_pend, stat_due, stat2_next;
		logic [2:0]  push_idx;
		logic [23:0] refresh_cnt;
		logic [7:0]  half_cnt;
		logic        phase;
		logic [4:0]  bit_cnt;
		logic [15:0] shift;
		logic [7:0]  rx;
		logic        sclk, cs, oe_n;
	} state_t;
	localparam state_t STATE_RESET = '{oe_n: 1'b1, state: ST_IDLE, kind: K_MANUAL, default: '0};
endpackage

// ==== design/three_wire_driver_link_master.sv ====
// three-wire serial master that keeps a laser driver's registers current
// assumes: APB master on pclk; driver answers on link_data_in, pins asynchronous
//
// Functional notes
// RULE1 - push shadows on supply, driver power-on, transmit-disable rise
// RULE2 - extra shadows sent only when selection enables
// RULE3 - code 00 equalizer/loss only; 01 nothing
// RULE4 - code 10 adds rx3; 11 adds tx2, tx3
// RULE5 - ignore bit 0: driver power-on flag triggers push
// RULE6 - ignore bit 1: driver power-on flag ignored
// RULE7 - start bit launches manual transfer from address/data
// RULE8 - address top bit picks read or write
// RULE9 - start bit clears when manual transfer ends
// RULE10 - disable bit stops all automatic traffic
// RULE11 - manual transfers still run while disabled
// RULE12 - control register resets to zero
// RULE13 - manual target address from address register
// RULE14 - manual write byte from write-data register
// RULE15 - writes need level two or level one plus rw
// RULE16 - reads need level two or level one plus permission
// RULE17 - manual read stores returned byte in read-data
// RULE18 - status registers polled every refresh interval
// RULE19 - manual waits for running automatic transfer
//
// Implementation choice: the APB slave port.
`include "tw_link_defs.svh"
module three_wire_driver_link_master #(
	parameter int unsigned REFRESH_CYCLES = `TW_REFRESH_CYC
)(
	input  wire logic        pclk,             // system clock, 200 MHz
	input  wire logic        presetn,          // asynchronous reset, active low
	input  wire logic        psel,             // apb select
	input  wire logic        penable,          // apb access phase
	input  wire logic        pwrite,           // apb direction
	input  wire logic [11:0] paddr,            // apb byte address
	input  wire logic [31:0] pwdata,           // apb write data
	input  wire logic [3:0]  pstrb,            // apb byte strobes
	output logic             pready,           // apb ready
	output logic      [31:0] prdata,           // apb read data
	output logic             pslverr,          // apb error
	input  wire logic        supply_above_poa, // supply past power-on-analog level
	input  wire logic        tx_disable,       // transmit disable pin
	output logic             link_clk_out,     // serial clock to driver
	output logic             link_select,      // frame select, high in a frame
	input  wire logic        link_data_in,     // serial data pin, input side
	output logic             link_data_out,    // serial data pin, output side
	output logic             link_data_oe_n    // serial data enable, low drives
);
	tw_link_pkg::state_t st_r;
	tw_link_pkg::state_t st_nxt;
	// ---------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------
	function automatic logic item_enabled(input logic [2:0] i, input logic [1:0] sel);
		logic en;
		unique case (i)
			3'h0, 3'h1: en = (sel != `TW_SEL_DEVICE); // RULE3
			3'h2:       en = sel[`TW_SEL_MSB]; // RULE4
			3'h3, 3'h4: en = (sel == `TW_SEL_ALL); // RULE4
			default:    en = 1'b0;
		endcase
		return en;
	endfunction
	function automatic logic [15:0] item_frame(input logic [2:0] i,
		input tw_link_pkg::state_t s);
		logic [15:0] f;
		unique case (i)
			3'h0:    f = {`TW_DRV_EQ, s.eq};
			3'h1:    f = {`TW_DRV_LOSS, s.loss};
			3'h2:    f = {`TW_DRV_RX3, s.rx3};
			3'h3:    f = {`TW_DRV_TX2, s.tx2};
			3'h4:    f = {`TW_DRV_TX3, s.tx3};
			default: f = 16'h0000;
		endcase
		return f;
	endfunction
	function automatic logic is_mapped(input logic [7:0] i);
		return i == `TW_IDX_EQ || i == `TW_IDX_LOSS || (i >= `TW_IDX_RX3 &&
			i <= `TW_IDX_STAT2) || i == `TW_IDX_ACCESS;
	endfunction

	// ---------------------------------------------------------------
	// combinational helpers
	// ---------------------------------------------------------------
	logic [7:0]  reg_idx;
	logic        addr_ok;
	logic        wr_ok;
	logic        rd_ok;
	logic        setup_ph;
	logic        wr_access;
	logic        tick;
	logic        frame_end;
	logic [7:0]  rx_new;
	logic        poa_rise;
	logic        txd_rise;
	logic [23:0] refresh_reload;
	logic [7:0]  half_reload;
	assign reg_idx   = paddr[9:2];
	assign addr_ok   = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && is_mapped(reg_idx);
	assign wr_ok     = st_r.acc[`TW_ACC_PW2] ||
		(st_r.acc[`TW_ACC_PW1] && st_r.acc[`TW_ACC_RW]); // RULE15
	assign rd_ok     = st_r.acc[`TW_ACC_PW2] || (st_r.acc[`TW_ACC_PW1] &&
		(st_r.acc[`TW_ACC_RW] || st_r.acc[`TW_ACC_RD])); // RULE16
	assign setup_ph  = psel && !penable;
	assign wr_access = psel && penable && pwrite && !st_r.pslverr && pstrb[0];
	assign tick      = st_r.half_cnt == 8'h00;
	assign frame_end = st_r.state == tw_link_pkg::ST_SHIFT && tick && st_r.phase &&
		st_r.bit_cnt == 5'(`TW_FRAME_BITS - 1);
	assign rx_new    = {st_r.rx[6:0], st_r.sdi_s};
	assign poa_rise  = st_r.poa_s && !st_r.poa_p;
	assign txd_rise  = st_r.txd_s && !st_r.txd_p;
	assign refresh_reload = 24'(REFRESH_CYCLES - 1);
	assign half_reload    = 8'(`TW_SCLK_HALF_CYC - 1);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [7:0]  rv;
		logic        err;
		logic        por_trig;
		logic        launch;
		logic [15:0] lf;
		tw_link_pkg::xfer_kind_t lk;
		rv       = `TW_REG_RESET;
		err      = 1'b0;
		por_trig = 1'b0;
		launch   = 1'b0;
		lf       = 16'h0000;
		lk       = tw_link_pkg::K_MANUAL;
		st_nxt   = st_r;
		// pins pass two flops before anything reads them
		st_nxt.txd_m = tx_disable;
		st_nxt.txd_s = st_r.txd_m;
		st_nxt.txd_p = st_r.txd_s;
		st_nxt.poa_m = supply_above_poa;
		st_nxt.poa_s = st_r.poa_m;
		st_nxt.poa_p = st_r.poa_s;
		st_nxt.sdi_m = link_data_in;
		st_nxt.sdi_s = st_r.sdi_m;
		unique case (st_r.state)
			tw_link_pkg::ST_IDLE:
			begin
				// only idle picks work, so frames never overlap
				if (st_r.start) // RULE19
				begin
					launch = 1'b1; // RULE7 RULE11
					lk     = tw_link_pkg::K_MANUAL;
					lf     = {st_r.addr, st_r.wdata}; // RULE13 RULE14
				end
				else if (!st_r.dis && st_r.push_active) // RULE10
				begin
					if (item_enabled(st_r.push_idx, st_r.setup[1:0])) // RULE2
					begin
						launch = 1'b1;
						lk     = tw_link_pkg::K_PUSH;
						lf     = item_frame(st_r.push_idx, st_r);
					end
					else if (st_r.push_idx == `TW_PUSH_LAST)
						st_nxt.push_active = 1'b0;
					else
						st_nxt.push_idx = st_r.push_idx + 3'h1;
				end
				else if (!st_r.dis && st_r.push_pend)
				begin
					st_nxt.push_active = 1'b1;
					st_nxt.push_idx    = 3'h0;
					st_nxt.push_pend   = 1'b0;
				end
				else if (!st_r.dis && st_r.stat2_next)
				begin
					launch = 1'b1;
					lk     = tw_link_pkg::K_STAT2;
					lf     = {`TW_DRV_STAT2 | 8'h80, 8'h00};
				end
				else if (!st_r.dis && st_r.stat_due)
				begin
					launch = 1'b1;
					lk     = tw_link_pkg::K_STAT1;
					lf     = {`TW_DRV_STAT1 | 8'h80, 8'h00};
					st_nxt.stat_due = 1'b0;
				end
				if (launch)
				begin
					st_nxt.state    = tw_link_pkg::ST_SHIFT;
					st_nxt.kind     = lk;
					st_nxt.shift    = lf;
					st_nxt.is_read  = lf[8 + `TW_READ_BIT]; // RULE8
					st_nxt.cs       = 1'b1;
					st_nxt.sclk     = 1'b0;
					st_nxt.phase    = 1'b0;
					st_nxt.bit_cnt  = 5'h00;
					st_nxt.half_cnt = half_reload;
					st_nxt.oe_n     = 1'b0;
				end
			end
			tw_link_pkg::ST_SHIFT:
			begin
				if (!tick)
					st_nxt.half_cnt = st_r.half_cnt - 8'h01;
				else
				begin
					st_nxt.half_cnt = half_reload;
					if (!st_r.phase)
					begin
						st_nxt.phase = 1'b1;
						st_nxt.sclk  = 1'b1;
					end
					else
					begin
						// sampled late in the high half: covers the two-flop delay
						st_nxt.rx    = rx_new;
						st_nxt.phase = 1'b0;
						st_nxt.sclk  = 1'b0;
						if (frame_end)
						begin
							st_nxt.state = tw_link_pkg::ST_IDLE;
							st_nxt.cs    = 1'b0;
							st_nxt.oe_n  = 1'b1;
						end
						else
						begin
							st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
							st_nxt.shift   = {st_r.shift[14:0], 1'b0};
							st_nxt.oe_n    = st_r.is_read && st_r.bit_cnt >= 5'h07;
						end
					end
				end
				if (frame_end)
				begin
					unique case (st_r.kind)
						tw_link_pkg::K_MANUAL:
						begin
							st_nxt.start = 1'b0; // RULE9
							if (st_r.is_read)
								st_nxt.rdata = rx_new; // RULE17
						end
						tw_link_pkg::K_PUSH:
						begin
							if (st_r.push_idx == `TW_PUSH_LAST)
								st_nxt.push_active = 1'b0;
							else
								st_nxt.push_idx = st_r.push_idx + 3'h1;
						end
						tw_link_pkg::K_STAT1:
						begin
							st_nxt.stat1      = rx_new;
							st_nxt.stat2_next = 1'b1;
							por_trig = !st_r.setup[`TW_IGNORE_BIT] && // RULE5 RULE6
								rx_new[`TW_POR_BIT] && !st_r.stat1[`TW_POR_BIT];
						end
						tw_link_pkg::K_STAT2:
						begin
							st_nxt.stat2      = rx_new;
							st_nxt.stat2_next = 1'b0;
						end
					endcase
				end
			end
		endcase
		// poll timer halts while automatic traffic is off; after the launch so a due poll is kept
		if (!st_r.dis)
		begin
			if (st_r.refresh_cnt == 24'h000000)
			begin
				st_nxt.refresh_cnt = refresh_reload;
				st_nxt.stat_due    = 1'b1; // RULE18
			end
			else
				st_nxt.refresh_cnt = st_r.refresh_cnt - 24'h000001;
		end
		// triggers set after the clear so a same-cycle event is kept
		if (poa_rise || txd_rise || por_trig) // RULE1
			st_nxt.push_pend = 1'b1;
		// apb setup: decode, check access, latch read data
		if (setup_ph)
		begin
			unique case (reg_idx)
				`TW_IDX_EQ:     rv = st_r.eq;
				`TW_IDX_LOSS:   rv = st_r.loss;
				`TW_IDX_RX3:    rv = st_r.rx3;
				`TW_IDX_TX2:    rv = st_r.tx2;
				`TW_IDX_TX3:    rv = st_r.tx3;
				`TW_IDX_SETUP:  rv = {5'h00, st_r.setup};
				`TW_IDX_CTRL:   rv = {6'h00, st_r.start, st_r.dis};
				`TW_IDX_ADDR:   rv = st_r.addr;
				`TW_IDX_WDATA:  rv = st_r.wdata;
				`TW_IDX_RDATA:  rv = st_r.rdata;
				`TW_IDX_STAT1:  rv = st_r.stat1;
				`TW_IDX_STAT2:  rv = st_r.stat2;
				`TW_IDX_ACCESS: rv = {4'h0, st_r.acc};
				default:        rv = `TW_REG_RESET;
			endcase
			if (!addr_ok)
				err = 1'b1;
			else if (reg_idx == `TW_IDX_ACCESS)
				err = 1'b0;
			else if (pwrite)
				err = !wr_ok || reg_idx >= `TW_IDX_RDATA; // RULE15
			else
				err = !rd_ok; // RULE16
			st_nxt.pslverr = err;
			st_nxt.prdata  = (err || pwrite) ? 32'h00000000 : {24'h000000, rv};
		end
		// apb access: writes land last, so software set beats hardware clear
		if (wr_access)
		begin
			unique case (reg_idx)
				`TW_IDX_EQ:     st_nxt.eq    = pwdata[7:0];
				`TW_IDX_LOSS:   st_nxt.loss  = pwdata[7:0];
				`TW_IDX_RX3:    st_nxt.rx3   = pwdata[7:0];
				`TW_IDX_TX2:    st_nxt.tx2   = pwdata[7:0];
				`TW_IDX_TX3:    st_nxt.tx3   = pwdata[7:0];
				`TW_IDX_SETUP:  st_nxt.setup = pwdata[2:0];
				`TW_IDX_CTRL:
				begin
					st_nxt.dis = pwdata[`TW_DIS_BIT]; // RULE10
					if (pwdata[`TW_START_BIT])
						st_nxt.start = 1'b1; // RULE7
				end
				`TW_IDX_ADDR:   st_nxt.addr  = pwdata[7:0];
				`TW_IDX_WDATA:  st_nxt.wdata = pwdata[7:0];
				`TW_IDX_ACCESS: st_nxt.acc   = pwdata[3:0];
				default:        st_nxt.acc   = st_r.acc;
			endcase
		end
	end
	// control register and all state but oe_n start at zero, link released
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= tw_link_pkg::STATE_RESET; // RULE12
		else
			st_r <= st_nxt;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign pready         = 1'b1;
	assign prdata         = st_r.prdata;
	assign pslverr        = st_r.pslverr;
	assign link_clk_out   = st_r.sclk;
	assign link_select    = st_r.cs;
	assign link_data_out  = st_r.shift[15];
	assign link_data_oe_n = st_r.oe_n;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence manual_end;
		frame_end && st_r.kind == tw_link_pkg::K_MANUAL;
	endsequence
	sequence manual_launch;
		st_r.state == tw_link_pkg::ST_IDLE && st_r.start;
	endsequence
	chk_trigger_push: assert property ((poa_rise || txd_rise) |=> st_r.push_pend) // RULE1
		else $error("push not requested after trigger");
	chk_push_gated: assert property (st_r.state == tw_link_pkg::ST_SHIFT && // RULE2
		st_r.kind == tw_link_pkg::K_PUSH |-> item_enabled(st_r.push_idx, st_r.setup[1:0]))
		else $error("disabled shadow sent");
	chk_device_mode: assert property (st_r.setup[1:0] == `TW_SEL_DEVICE && // RULE3
		st_r.state == tw_link_pkg::ST_IDLE |=> st_r.kind != tw_link_pkg::K_PUSH ||
		st_r.state == tw_link_pkg::ST_IDLE)
		else $error("push in device mode");
	chk_por_monitor: assert property (frame_end && st_r.kind == tw_link_pkg::K_STAT1 && // RULE5
		!st_r.setup[`TW_IGNORE_BIT] && rx_new[7] && !st_r.stat1[7] |=> st_r.push_pend)
		else $error("driver power-on flag missed");
	chk_por_ignore: assert property (frame_end && st_r.setup[`TW_IGNORE_BIT] && // RULE6
		!st_r.push_pend && !poa_rise && !txd_rise |=> !st_r.push_pend)
		else $error("ignored power-on flag pushed");
	chk_manual_frame: assert property (manual_launch |=> // RULE13 RULE14
		st_r.shift == {$past(st_r.addr), $past(st_r.wdata)} ##1 st_r.cs [*8])
		else $error("manual frame wrong");
	chk_start_clear: assert property (manual_end ##0 !wr_access |=> !st_r.start) // RULE9
		else $error("start bit not cleared");
	chk_read_store: assert property (manual_end ##0 st_r.is_read |=> // RULE17
		st_r.rdata == $past(rx_new))
		else $error("read byte not stored");
	chk_auto_off: assert property (st_r.dis && st_r.state == tw_link_pkg::ST_IDLE // RULE10
		|=> st_r.state == tw_link_pkg::ST_IDLE || st_r.kind == tw_link_pkg::K_MANUAL)
		else $error("automatic frame while disabled");
	chk_no_overlap: assert property (st_r.state == tw_link_pkg::ST_SHIFT && // RULE19
		!frame_end |=> st_r.state == tw_link_pkg::ST_SHIFT && $stable(st_r.kind))
		else $error("frame interrupted");
	chk_write_deny: assert property (setup_ph && pwrite && addr_ok && !wr_ok && // RULE15
		reg_idx != `TW_IDX_ACCESS |=> pslverr)
		else $error("write allowed without password");
	chk_read_deny: assert property (setup_ph && !pwrite && addr_ok && !rd_ok && // RULE16
		reg_idx != `TW_IDX_ACCESS |=> pslverr && prdata == 32'h00000000)
		else $error("read allowed without password");
	chk_poll_due: assert property (!st_r.dis && st_r.refresh_cnt == 24'h000000 // RULE18
		|=> st_r.stat_due || st_r.kind == tw_link_pkg::K_STAT1)
		else $error("status poll not scheduled");
endmodule

// ==== bench/laser_driver_model.sv ====
// behavioural laser driver: serial slave on the three-wire link
// assumes: the bench resolves the shared data wire and feeds it back here
`include "tw_link_defs.svh"
module laser_driver_model
(
	input  wire logic link_clk_out, // serial clock from the master
	input  wire logic link_select,  // frame select, high in a frame
	input  wire logic data_wire,    // resolved data line
	output logic      drv_en,       // model drives the data line
	output logic      drv_bit       // bit driven during a read
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:127];
	logic [15:0] frames [$];
	logic [15:0] sh;
	logic [7:0]  adr;
	logic [7:0]  dat;
	int          cnt;
	int          polls;

	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
		drv_en = 1'b0;
		drv_bit = 1'b0;
		cnt = 0;
		polls = 0;
		sh = 16'h0000;
		adr = 8'h00;
	end

	// ---------------------------------------------------------------
	// bit capture and read answer
	// ---------------------------------------------------------------
	// data changes on the rising clock so it is settled long before the
	// master samples on the falling one
	always @(posedge link_clk_out)
	begin
		if (link_select)
		begin
			if (cnt == 8)
				adr = sh[7:0];
			if (cnt >= 8 && adr[7])
			begin
				drv_en = 1'b1;
				drv_bit = mem[adr[6:0]][15 - cnt];
			end
			sh = {sh[14:0], data_wire};
			cnt = cnt + 1;
		end
	end

	// ---------------------------------------------------------------
	// frame end: log it; status polls are only counted
	// ---------------------------------------------------------------
	// a cut or partial frame is dropped
	always @(negedge link_select)
	begin
		drv_en = 1'b0;
		if (cnt == 16)
		begin
			dat = adr[7] ? mem[adr[6:0]] : sh[7:0];
			if (adr == (`TW_DRV_STAT1 | 8'h80) || adr == (`TW_DRV_STAT2 | 8'h80))
				polls = polls + 1;
			else
				frames.push_back({adr, dat});
			if (!adr[7])
				mem[adr[6:0]] = sh[7:0];
		end
		cnt = 0;
	end
endmodule

// ==== bench/tb_top.sv ====
// register-level bench for the three-wire link master
// assumes: laser_driver_model on the link, tw_link_defs.svh on include path
`include "tw_link_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned REFRESH = 2000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        supply, txd, lclk, lsel, ldo, loe_n, dwire, dwire_q, den, dbit;
	int          fail_count, checked, p, w;
	logic [7:0]  sh_idx [5] = '{`TW_IDX_EQ, `TW_IDX_LOSS, `TW_IDX_RX3, `TW_IDX_TX2, `TW_IDX_TX3};
	logic [7:0]  rv_idx [11] = '{8'hf1, 8'hf2, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9,
		8'hfa, 8'hfb, 8'hfc};
	int          en_cnt [4] = '{2, 0, 3, 5};

	three_wire_driver_link_master #(.REFRESH_CYCLES(REFRESH)) i_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.supply_above_poa(supply), .tx_disable(txd), .link_clk_out(lclk),
		.link_select(lsel), .link_data_in(dwire), .link_data_out(ldo),
		.link_data_oe_n(loe_n));
	laser_driver_model i_drv (.link_clk_out(lclk), .link_select(lsel), .data_wire(dwire),
		.drv_en(den), .drv_bit(dbit));

	// an undriven line flips every cycle so a stale level never passes
	assign dwire = !loe_n ? ldo : (den ? dbit : ~dwire_q);
	always @(posedge pclk)
		dwire_q <= presetn ? dwire : 1'b0;

	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ---------------------------------------------------------------
	// reporting and bounded waits
	// ---------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
		checked++;
		if (got !== x)
		begin
			$display("wrong value %s expected %h seen %h", what, x, got);
			fail_count++;
		end
	endtask

	task automatic tick(inout int n, input int lim);
		@(posedge pclk);
		n++;
		if (n > lim)
		begin
			fail_count++;
			results();
		end
	endtask

	// ---------------------------------------------------------------
	// apb master
	// ---------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] r, output logic er);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		tick(n, 50);
		while (pready !== 1'b1)
			tick(n, 50);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic e);
		logic [31:0] r;
		logic        er;
		apb(1'b1, idx, d, r, er);
		chk("pslverr", {31'h0, e}, {31'h0, er});
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] x, input logic e);
		logic [31:0] r;
		logic        er;
		apb(1'b0, idx, 8'h00, r, er);
		chk("pslverr", {31'h0, e}, {31'h0, er});
		chk("prdata", {24'h0, x}, r);
	endtask

	// ---------------------------------------------------------------
	// link observation
	// ---------------------------------------------------------------
	task automatic frame(input logic [15:0] x);
		int n;
		n = 0;
		while (i_drv.frames.size() == 0)
			tick(n, 5000);
		chk("frame", {16'h0, x}, {16'h0, i_drv.frames.pop_front()});
	endtask

	task automatic quiet(input int cyc);
		repeat (cyc) @(posedge pclk);
		chk("extra frames", 32'h0, 32'(i_drv.frames.size()));
	endtask

	task automatic push_chk(input int k);
		for (int i = 0; i < k; i++)
			frame({8'(i + 1), 8'(8'h11 * (i + 1))});
		quiet(600);
	endtask

	task automatic wait_poll();
		int n;
		int q;
		n = 0;
		q = i_drv.polls;
		while (i_drv.polls < q + 3)
			tick(n, 4 * REFRESH);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, supply, txd} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		fail_count = 0;
		checked = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(`TW_IDX_CTRL, 8'h00, 1'b1);
		wr(`TW_IDX_SETUP, 8'h03, 1'b1);
		wr(`TW_IDX_ACCESS, 8'h09, 1'b0);
		rd(`TW_IDX_SETUP, 8'h00, 1'b0);
		wr(`TW_IDX_SETUP, 8'h03, 1'b1);
		wr(`TW_IDX_ACCESS, 8'h01, 1'b0);
		rd(`TW_IDX_SETUP, 8'h00, 1'b1);
		wr(`TW_IDX_ACCESS, 8'h05, 1'b0);
		wr(`TW_IDX_SETUP, 8'h00, 1'b0);
		wr(`TW_IDX_ACCESS, 8'h02, 1'b0);
		foreach (rv_idx[i])
			rd(rv_idx[i], `TW_REG_RESET, 1'b0);
		rd(8'hf3, 8'h00, 1'b1);
		wr(`TW_IDX_RDATA, 8'h55, 1'b1);
		wr(`TW_IDX_ADDR, 8'h07, 1'b0);
		wr(`TW_IDX_WDATA, 8'ha5, 1'b0);
		wr(`TW_IDX_CTRL, 8'h02, 1'b0);
		rd(`TW_IDX_CTRL, 8'h02, 1'b0);
		frame(16'h07a5);
		rd(`TW_IDX_CTRL, 8'h00, 1'b0);
		i_drv.mem[9] = 8'h3c;
		wr(`TW_IDX_ADDR, 8'h89, 1'b0);
		wr(`TW_IDX_CTRL, 8'h02, 1'b0);
		frame(16'h893c);
		rd(`TW_IDX_RDATA, 8'h3c, 1'b0);
		foreach (sh_idx[i])
			wr(sh_idx[i], 8'(8'h11 * (i + 1)), 1'b0);
		for (int s = 0; s < 4; s++)
		begin
			wr(`TW_IDX_SETUP, 8'(s), 1'b0);
			txd <= 1'b1;
			push_chk(en_cnt[s]);
			txd <= 1'b0;
		end
		wr(`TW_IDX_ADDR, 8'h06, 1'b0);
		wr(`TW_IDX_WDATA, 8'h5a, 1'b0);
		wr(`TW_IDX_SETUP, 8'h00, 1'b0);
		supply <= 1'b1;
		// start lands while the first shadow frame is on the wire, not behind a poll
		w = 0;
		while (!(lsel && i_drv.adr == `TW_DRV_EQ))
			tick(w, 3000);
		wr(`TW_IDX_CTRL, 8'h02, 1'b0);
		frame(16'h0111);
		frame(16'h065a);
		frame(16'h0222);
		wr(`TW_IDX_SETUP, 8'h04, 1'b0);
		i_drv.mem[`TW_DRV_STAT1] = 8'h00;
		i_drv.mem[`TW_DRV_STAT2] = 8'h5c;
		wait_poll();
		i_drv.mem[`TW_DRV_STAT1] = 8'h80;
		wait_poll();
		rd(`TW_IDX_STAT1, 8'h80, 1'b0);
		rd(`TW_IDX_STAT2, 8'h5c, 1'b0);
		quiet(600);
		wr(`TW_IDX_SETUP, 8'h00, 1'b0);
		i_drv.mem[`TW_DRV_STAT1] = 8'h00;
		wait_poll();
		i_drv.mem[`TW_DRV_STAT1] = 8'h80;
		push_chk(2);
		wr(`TW_IDX_CTRL, 8'h01, 1'b0);
		repeat (600) @(posedge pclk);
		p = i_drv.polls;
		txd <= 1'b1;
		quiet(3 * REFRESH);
		chk("polls", 32'(p), 32'(i_drv.polls));
		wr(`TW_IDX_WDATA, 8'h77, 1'b0);
		wr(`TW_IDX_CTRL, 8'h03, 1'b0);
		frame(16'h0677);
		wr(`TW_IDX_CTRL, 8'h00, 1'b0);
		push_chk(2);
		results();
	end
endmodule
